// ===== src/spce_cfg.svh
// constants for the scsi phase command engine: field positions, ranges, codes
`ifndef SPCE_CFG_SVH
`define SPCE_CFG_SVH

`define SPCE_PH_DATA_IN   3'h1
`define SPCE_PH_STATUS    3'h3
`define SPCE_PH_MSG_IN    3'h7

`define SPCE_CFG_NO_DISCONNECT_FLAG   2
`define SPCE_CFG_BUF_HI   5
`define SPCE_CFG_BUF_LO   4
`define SPCE_CFG_MAX      33'h0_0000_0034
`define SPCE_SIZE_MIN     33'h0_0000_0002
`define SPCE_SIZE_MAX     33'h1_0000_0000

`define SPCE_CFG_RST      8'h00
`define SPCE_METHOD_RST   2'h0
`define SPCE_BUFSZ_RST    33'h0_0001_0000

`define SPCE_ERR_NONE     8'h00
`define SPCE_ERR_ARG      8'hE1
`define SPCE_ERR_PHASE    8'hE2

`define SPCE_CH_CR        8'h0D
`define SPCE_CH_LF        8'h0A
`define SPCE_CH_SPACE     8'h20
`define SPCE_CH_COMMA     8'h2C
`define SPCE_CH_QUERY     8'h3F
`define SPCE_CH_HASH      8'h23
`define SPCE_CH_0         8'h30
`define SPCE_CH_9         8'h39
`define SPCE_CH_UA        8'h41
`define SPCE_CH_UF        8'h46
`define SPCE_CH_UH        8'h48
`define SPCE_CH_LA        8'h61
`define SPCE_CH_LF_       8'h66
`define SPCE_CH_LH        8'h68

`define SPCE_QUERY_LAST   3'h7

`endif

// ===== src/spce_pkg.sv
// types shared by the scsi phase command engine
package spce_pkg;

	typedef enum logic [1:0] {
		spce_cmd_cmp,
		spce_cmd_config,
		spce_cmd_dtin
	} spce_cmd_t;

	typedef enum logic [3:0] {
		st_idle,
		st_args,
		st_eval,
		st_query,
		st_cmp_stat,
		st_cmp_msg,
		st_dtin,
		st_err
	} spce_state_t;

endpackage : spce_pkg

// ===== src/spce_arg_parser.sv
// argument parser: up to two decimal or #h hex values, or a query mark
`timescale 1ns/10ps
`include "spce_cfg.svh"
module spce_arg_parser
	import spce_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        reset_n_i,
	input  wire logic        clear_i,
	input  wire logic        char_valid_i,
	input  wire logic [7:0]  char_i,
	output logic             any_o,
	output logic             query_o,
	output logic             bad_o,
	output logic [1:0]       nvals_o,
	output logic [32:0]      val0_o,
	output logic [32:0]      val1_o
);
	logic        slot;
	logic        hex;
	logic        want_h;
	logic        next_any;
	logic        next_query;
	logic        next_bad;
	logic [1:0]  next_nvals;
	logic [32:0] next_val0;
	logic [32:0] next_val1;
	logic        next_slot;
	logic        next_hex;
	logic        next_want_h;
	logic [36:0] acc;
	logic [3:0]  dig;
	logic        is_dig;

	always_comb begin
		next_any = any_o;
		next_query = query_o;
		next_bad = bad_o;
		next_nvals = nvals_o;
		next_val0 = val0_o;
		next_val1 = val1_o;
		next_slot = slot;
		next_hex = hex;
		next_want_h = want_h;
		is_dig = 1'b1;
		dig = 4'h0;
		if (char_i >= `SPCE_CH_0 && char_i <= `SPCE_CH_9) begin
			dig = 4'(char_i - `SPCE_CH_0);
		end else if (hex && char_i >= `SPCE_CH_LA && char_i <= `SPCE_CH_LF_) begin
			dig = 4'(char_i - `SPCE_CH_LA + 8'h0A);
		end else if (hex && char_i >= `SPCE_CH_UA && char_i <= `SPCE_CH_UF) begin
			dig = 4'(char_i - `SPCE_CH_UA + 8'h0A);
		end else begin
			is_dig = 1'b0;
		end
		// widened so a value past 33 bits shows up as overflow, not wrap
		acc = hex ? {slot ? val1_o : val0_o, 4'h0} + 37'(dig)
			: 37'({slot ? val1_o : val0_o, 3'h0}) + 37'({slot ? val1_o : val0_o, 1'b0})
			+ 37'(dig);
		if (clear_i) begin
			next_any = 1'b0;
			next_query = 1'b0;
			next_bad = 1'b0;
			next_nvals = 2'h0;
			next_val0 = 33'h0_0000_0000;
			next_val1 = 33'h0_0000_0000;
			next_slot = 1'b0;
			next_hex = 1'b0;
			next_want_h = 1'b0;
		end else if (char_valid_i) begin
			next_any = 1'b1;
			if (want_h) begin
				next_want_h = 1'b0;
				next_hex = 1'b1;
				next_bad = bad_o | (char_i != `SPCE_CH_LH && char_i != `SPCE_CH_UH);
			end else if (is_dig) begin
				next_nvals = {1'b0, 1'b1} + {1'b0, slot};
				next_bad = bad_o | (acc[36:33] != 4'h0) | query_o;
				if (slot) begin
					next_val1 = acc[32:0];
				end else begin
					next_val0 = acc[32:0];
				end
			end else if (char_i == `SPCE_CH_HASH) begin
				next_want_h = 1'b1;
			end else if (char_i == `SPCE_CH_COMMA) begin
				next_bad = bad_o | slot | (nvals_o == 2'h0);
				next_slot = 1'b1;
				next_hex = 1'b0;
			end else if (char_i == `SPCE_CH_QUERY) begin
				next_bad = bad_o | (nvals_o != 2'h0) | query_o;
				next_query = 1'b1;
			end else if (char_i != `SPCE_CH_SPACE) begin
				next_bad = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			any_o <= 1'b0;
			query_o <= 1'b0;
			bad_o <= 1'b0;
			nvals_o <= 2'h0;
			val0_o <= 33'h0_0000_0000;
			val1_o <= 33'h0_0000_0000;
			slot <= 1'b0;
			hex <= 1'b0;
			want_h <= 1'b0;
		end else begin
			any_o <= next_any;
			query_o <= next_query;
			bad_o <= next_bad;
			nvals_o <= next_nvals;
			val0_o <= next_val0;
			val1_o <= next_val1;
			slot <= next_slot;
			hex <= next_hex;
			want_h <= next_want_h;
		end
	end
endmodule : spce_arg_parser

// ===== src/spce_scsi_rx.sv
// scsi req/ack receiver for target-to-initiator byte phases
`timescale 1ns/10ps
module spce_scsi_rx (
	input  wire logic        clock_i,
	input  wire logic        reset_n_i,
	input  wire logic        accept_i,
	input  wire logic        req_i,
	input  wire logic [7:0]  data_i,
	output logic             ack_o,
	output logic             byte_valid_o,
	output logic [7:0]       byte_o
);
	logic       next_ack;
	logic       next_valid;
	logic [7:0] next_byte;

	always_comb begin
		next_ack = ack_o;
		next_valid = 1'b0;
		next_byte = byte_o;
		if (!ack_o && req_i && accept_i) begin
			next_ack = 1'b1;
			next_valid = 1'b1;
			next_byte = data_i;
		end else if (ack_o && !req_i) begin
			next_ack = 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ack_o <= 1'b0;
			byte_valid_o <= 1'b0;
			byte_o <= 8'h00;
		end else begin
			ack_o <= next_ack;
			byte_valid_o <= next_valid;
			byte_o <= next_byte;
		end
	end
endmodule : spce_scsi_rx

// ===== src/spce_engine.sv
// command engine: completion, configuration and data-in commands
`timescale 1ns/10ps
`include "spce_cfg.svh"
module spce_engine
	import spce_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        reset_n_i,
	input  wire logic        cmd_valid_i,
	input  wire spce_cmd_t   cmd_code_i,
	input  wire logic        arg_valid_i,
	input  wire logic [7:0]  arg_char_i,
	input  wire logic        arg_end_i,
	input  wire logic [32:0] dram_free_i,
	input  wire logic        scsi_req_i,
	input  wire logic        scsi_bsy_i,
	input  wire logic [2:0]  scsi_phase_i,
	input  wire logic [7:0]  scsi_data_i,
	output logic             scsi_ack_o,
	output logic [7:0]       gdata_o,
	output logic             gdata_valid_o,
	output logic             gdata_eoi_o,
	input  wire logic        gdata_ready_i,
	output logic [7:0]       stat_byte_o,
	output logic             stat_valid_o,
	input  wire logic        stat_ready_i,
	output logic [7:0]       config_byte_o,
	output logic [1:0]       buf_method_o,
	output logic [32:0]      buf_size_o,
	output logic             identify_disc_o,
	output logic [7:0]       err_code_o,
	output logic             busy_o,
	output logic             done_o
);
	spce_state_t state;
	spce_state_t next_state;
	spce_cmd_t   cmd;
	spce_cmd_t   next_cmd;
	logic [2:0]  qidx;
	logic [2:0]  next_qidx;
	logic        got_msg;
	logic        next_got_msg;
	logic [7:0]  held;
	logic [7:0]  next_held;
	logic        held_valid;
	logic        next_held_valid;
	logic [7:0]  next_gdata;
	logic        next_gdata_valid;
	logic        next_eoi;
	logic [7:0]  next_stat_byte;
	logic        next_stat_valid;
	logic [7:0]  next_cfg;
	logic [1:0]  next_method;
	logic [32:0] next_size;
	logic        next_disc;
	logic [7:0]  next_err;
	logic        next_busy;
	logic        next_done;
	logic        accept;
	logic        parse_clear;
	logic        rx_ack;
	logic        rx_valid;
	logic [7:0]  rx_byte;
	logic        p_any;
	logic        p_query;
	logic        p_bad;
	logic [1:0]  p_nvals;
	logic [32:0] p_val0;
	logic [32:0] p_val1;
	logic        end_data;

	// a fresh request not yet acknowledged, in a phase other than the wanted one
	function automatic logic wrong_phase(input logic req, input logic ack,
		input logic [2:0] ph, input logic [2:0] want);
		wrong_phase = req & ~ack & (ph != want);
	endfunction : wrong_phase

	function automatic logic fresh_req(input logic req, input logic ack,
		input logic [2:0] ph, input logic [2:0] want);
		fresh_req = req & ~ack & (ph == want);
	endfunction : fresh_req

	// query reply: configuration byte, size as five bytes msb first, cr, lf
	function automatic logic [7:0] query_byte(input logic [2:0] idx,
		input logic [7:0] cfg, input logic [32:0] size);
		logic [39:0] wide;
		wide = {7'h00, size};
		case (idx)
			3'h0: query_byte = cfg;
			3'h1: query_byte = wide[39:32];
			3'h2: query_byte = wide[31:24];
			3'h3: query_byte = wide[23:16];
			3'h4: query_byte = wide[15:8];
			3'h5: query_byte = wide[7:0];
			3'h6: query_byte = `SPCE_CH_CR;
			default: query_byte = `SPCE_CH_LF;
		endcase
	endfunction : query_byte

	spce_arg_parser u_parser (
		.clock_i      (clock_i),
		.reset_n_i    (reset_n_i),
		.clear_i      (parse_clear),
		.char_valid_i (arg_valid_i),
		.char_i       (arg_char_i),
		.any_o        (p_any),
		.query_o      (p_query),
		.bad_o        (p_bad),
		.nvals_o      (p_nvals),
		.val0_o       (p_val0),
		.val1_o       (p_val1)
	);

	spce_scsi_rx u_rx (
		.clock_i      (clock_i),
		.reset_n_i    (reset_n_i),
		.accept_i     (accept),
		.req_i        (scsi_req_i),
		.data_i       (scsi_data_i),
		.ack_o        (rx_ack),
		.byte_valid_o (rx_valid),
		.byte_o       (rx_byte)
	);

	assign scsi_ack_o = rx_ack;

	// the last data-in byte is only known once the target leaves the phase
	assign end_data = held_valid & ~rx_valid & ~gdata_valid_o
		& (wrong_phase(scsi_req_i, rx_ack, scsi_phase_i, `SPCE_PH_DATA_IN) | ~scsi_bsy_i);

	always_comb begin
		next_state = state;
		next_cmd = cmd;
		next_qidx = qidx;
		next_got_msg = got_msg;
		next_held = held;
		next_held_valid = held_valid;
		next_gdata = gdata_o;
		next_gdata_valid = gdata_valid_o & ~gdata_ready_i;
		next_eoi = gdata_eoi_o & ~gdata_ready_i;
		next_stat_byte = stat_byte_o;
		next_stat_valid = stat_valid_o & ~stat_ready_i;
		next_cfg = config_byte_o;
		next_method = buf_method_o;
		next_size = buf_size_o;
		next_err = err_code_o;
		next_done = 1'b0;
		accept = 1'b0;
		parse_clear = 1'b0;
		case (state)
			st_idle: begin
				if (cmd_valid_i) begin
					next_cmd = cmd_code_i;
					parse_clear = 1'b1;
					next_state = st_args;
				end
			end
			st_args: begin
				if (arg_end_i) begin
					next_state = st_eval;
				end
			end
			st_eval: begin
				next_err = `SPCE_ERR_NONE;
				next_got_msg = 1'b0;
				next_held_valid = 1'b0;
				case (cmd)
					spce_cmd_cmp: begin
						if (p_any) begin
							next_err = `SPCE_ERR_ARG;
							next_state = st_err;
						end else begin
							next_state = st_cmp_stat;
						end
					end
					spce_cmd_dtin: begin
						if (p_any) begin
							next_err = `SPCE_ERR_ARG;
							next_state = st_err;
						end else begin
							next_state = st_dtin;
						end
					end
					default: begin
						// every check runs before any setting is touched
						if (p_bad) begin
							next_err = `SPCE_ERR_ARG;
							next_state = st_err;
						end else if (p_query) begin
							if (p_nvals != 2'h0) begin
								next_err = `SPCE_ERR_ARG;
								next_state = st_err;
							end else begin
								next_qidx = 3'h0;
								next_state = st_query;
							end
						end else if (p_nvals == 2'h0) begin
							next_err = `SPCE_ERR_ARG;
							next_state = st_err;
						end else if (p_val0 > `SPCE_CFG_MAX) begin
							next_err = `SPCE_ERR_ARG;
							next_state = st_err;
						end else if (p_nvals == 2'h2 && (p_val1 < `SPCE_SIZE_MIN
							|| p_val1 > `SPCE_SIZE_MAX)) begin
							next_err = `SPCE_ERR_ARG;
							next_state = st_err;
						end else begin
							next_cfg = p_val0[7:0];
							if (p_val0[`SPCE_CFG_BUF_HI:`SPCE_CFG_BUF_LO] != 2'h0) begin
								next_method = p_val0[`SPCE_CFG_BUF_HI:`SPCE_CFG_BUF_LO];
							end
							if (p_nvals == 2'h2) begin
								next_size = (p_val1 < dram_free_i) ? p_val1 : dram_free_i;
							end
							next_done = 1'b1;
							next_state = st_idle;
						end
					end
				endcase
			end
			st_query: begin
				if (!stat_valid_o) begin
					next_stat_byte = query_byte(qidx, config_byte_o, buf_size_o);
					next_stat_valid = 1'b1;
					next_qidx = qidx + 3'h1;
					if (qidx == `SPCE_QUERY_LAST) begin
						next_done = 1'b1;
						next_state = st_idle;
					end
				end
			end
			st_cmp_stat: begin
				accept = fresh_req(scsi_req_i, rx_ack, scsi_phase_i, `SPCE_PH_STATUS)
					& ~stat_valid_o;
				if (rx_valid) begin
					next_stat_byte = rx_byte;
					next_stat_valid = 1'b1;
					next_state = st_cmp_msg;
				end else if (wrong_phase(scsi_req_i, rx_ack, scsi_phase_i, `SPCE_PH_STATUS)
					|| !scsi_bsy_i) begin
					next_err = `SPCE_ERR_PHASE;
					next_state = st_err;
				end
			end
			st_cmp_msg: begin
				accept = fresh_req(scsi_req_i, rx_ack, scsi_phase_i, `SPCE_PH_MSG_IN)
					& ~stat_valid_o;
				if (rx_valid) begin
					next_stat_byte = rx_byte;
					next_stat_valid = 1'b1;
					next_got_msg = 1'b1;
				end else if (wrong_phase(scsi_req_i, rx_ack, scsi_phase_i, `SPCE_PH_MSG_IN)) begin
					next_err = `SPCE_ERR_PHASE;
					next_state = st_err;
				end else if (!scsi_bsy_i && !rx_ack) begin
					// bus free ends the message phase; it needs at least one byte
					if (got_msg) begin
						next_done = 1'b1;
						next_state = st_idle;
					end else begin
						next_err = `SPCE_ERR_PHASE;
						next_state = st_err;
					end
				end
			end
			st_dtin: begin
				accept = fresh_req(scsi_req_i, rx_ack, scsi_phase_i, `SPCE_PH_DATA_IN)
					& ~gdata_valid_o;
				if (rx_valid) begin
					if (held_valid) begin
						next_gdata = held;
						next_gdata_valid = 1'b1;
						next_eoi = 1'b0;
					end
					next_held = rx_byte;
					next_held_valid = 1'b1;
				end else if (end_data) begin
					next_gdata = held;
					next_gdata_valid = 1'b1;
					next_eoi = 1'b1;
					next_held_valid = 1'b0;
					next_done = 1'b1;
					next_state = st_idle;
				end else if (!held_valid && ((scsi_req_i && !rx_ack
					&& scsi_phase_i == `SPCE_PH_STATUS) || !scsi_bsy_i)) begin
					next_err = `SPCE_ERR_PHASE;
					next_state = st_err;
				end
			end
			st_err: begin
				// the code waits for room on the status channel, never dropped
				if (!stat_valid_o) begin
					next_stat_byte = err_code_o;
					next_stat_valid = 1'b1;
					next_done = 1'b1;
					next_state = st_idle;
				end
			end
			default: begin
				next_state = st_idle;
			end
		endcase
		next_busy = (next_state != st_idle);
		next_disc = ~next_cfg[`SPCE_CFG_NO_DISCONNECT_FLAG];
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= st_idle;
			cmd <= spce_cmd_cmp;
			qidx <= 3'h0;
			got_msg <= 1'b0;
			held <= 8'h00;
			held_valid <= 1'b0;
			gdata_o <= 8'h00;
			gdata_valid_o <= 1'b0;
			gdata_eoi_o <= 1'b0;
			stat_byte_o <= 8'h00;
			stat_valid_o <= 1'b0;
			config_byte_o <= `SPCE_CFG_RST;
			buf_method_o <= `SPCE_METHOD_RST;
			buf_size_o <= `SPCE_BUFSZ_RST;
			identify_disc_o <= 1'b1;
			err_code_o <= `SPCE_ERR_NONE;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			state <= next_state;
			cmd <= next_cmd;
			qidx <= next_qidx;
			got_msg <= next_got_msg;
			held <= next_held;
			held_valid <= next_held_valid;
			gdata_o <= next_gdata;
			gdata_valid_o <= next_gdata_valid;
			gdata_eoi_o <= next_eoi;
			stat_byte_o <= next_stat_byte;
			stat_valid_o <= next_stat_valid;
			config_byte_o <= next_cfg;
			buf_method_o <= next_method;
			buf_size_o <= next_size;
			identify_disc_o <= next_disc;
			err_code_o <= next_err;
			busy_o <= next_busy;
			done_o <= next_done;
		end
	end
endmodule : spce_engine

// ===== tb/spce_assertions.sv
// checker for the command engine: handshakes, settings and output streams
`timescale 1ns/10ps
module spce_assertions (
	input	wire logic		clock_i,
	input	wire logic		reset_n_i,
	input	wire logic		scsi_req_i,
	input	wire logic		scsi_ack_o,
	input	wire logic	[32:0]	dram_free_i,
	input	wire logic	[7:0]	config_byte_o,
	input	wire logic	[32:0]	buf_size_o,
	input	wire logic		identify_disc_o,
	input	wire logic	[7:0]	err_code_o,
	input	wire logic		done_o,
	input	wire logic	[7:0]	gdata_o,
	input	wire logic		gdata_valid_o,
	input	wire logic		gdata_eoi_o,
	input	wire logic		gdata_ready_i,
	input	wire logic	[7:0]	stat_byte_o,
	input	wire logic		stat_valid_o,
	input	wire logic		stat_ready_i
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);

	property p_ack_rise;
		$rose(scsi_ack_o) |-> $past(scsi_req_i);
	endproperty
	a_ack_rise: assert property (p_ack_rise) else $error("ack rose with no request");
	property p_ack_fall;
		scsi_ack_o && !scsi_req_i |=> !scsi_ack_o;
	endproperty
	a_ack_fall: assert property (p_ack_fall) else $error("ack held after request gone");
	property p_ident;
		identify_disc_o == !config_byte_o[2];
	endproperty
	a_ident: assert property (p_ident) else $error("identify bit disagrees with flag");
	property p_cfg_range;
		$changed(config_byte_o) |-> config_byte_o <= 8'h34;
	endproperty
	a_cfg_range: assert property (p_cfg_range) else $error("config byte above limit");
	property p_commit;
		$changed(config_byte_o) || $changed(buf_size_o) |-> done_o && err_code_o == 8'h00;
	endproperty
	a_commit: assert property (p_commit) else $error("settings moved outside success");
	property p_size;
		$changed(buf_size_o) |-> buf_size_o >= 33'h2 && buf_size_o <= dram_free_i;
	endproperty
	a_size: assert property (p_size) else $error("buffer size out of bounds");
	property p_eoi;
		gdata_eoi_o |-> gdata_valid_o;
	endproperty
	a_eoi: assert property (p_eoi) else $error("end flag without a byte");
	property p_gdata_hold;
		gdata_valid_o && !gdata_ready_i |=> gdata_valid_o && $stable(gdata_o) && $stable(gdata_eoi_o);
	endproperty
	a_gdata_hold: assert property (p_gdata_hold) else $error("data byte dropped");
	property p_stat_hold;
		stat_valid_o && !stat_ready_i |=> stat_valid_o && $stable(stat_byte_o);
	endproperty
	a_stat_hold: assert property (p_stat_hold) else $error("status byte dropped");
endmodule : spce_assertions

bind spce_engine spce_assertions u_spce_assertions (
	.clock_i(clock_i), .reset_n_i(reset_n_i), .scsi_req_i(scsi_req_i),
	.scsi_ack_o(scsi_ack_o), .dram_free_i(dram_free_i), .config_byte_o(config_byte_o),
	.buf_size_o(buf_size_o), .identify_disc_o(identify_disc_o), .err_code_o(err_code_o),
	.done_o(done_o), .gdata_o(gdata_o), .gdata_valid_o(gdata_valid_o),
	.gdata_eoi_o(gdata_eoi_o), .gdata_ready_i(gdata_ready_i), .stat_byte_o(stat_byte_o),
	.stat_valid_o(stat_valid_o), .stat_ready_i(stat_ready_i)
);

// ===== tb/spce_target_model.sv
// behavioural scsi target sending bytes by req/ack
`timescale 1ns/10ps
module spce_target_model (
	input	wire logic		clock_i,
	input	wire logic		ack_i,
	output	logic			req_o,
	output	logic			bsy_o,
	output	logic	[2:0]	phase_o,
	output	logic	[7:0]	data_o
);
	initial begin
		req_o = 1'b0;
		bsy_o = 1'b0;
		phase_o = 3'h0;
		data_o = 8'h5A;
	end
	task automatic hold_bus;
		@(negedge clock_i);
		bsy_o = 1'b1;
	endtask : hold_bus
	// nobody drives the data lines on a free bus, so they flip instead of keeping the byte
	task automatic free_bus;
		@(negedge clock_i);
		bsy_o = 1'b0;
		data_o = ~data_o;
	endtask : free_bus
	// a request left unacked is withdrawn after a while so a refused phase cannot hang
	task automatic offer(input logic [2:0] ph, input logic [7:0] d, input int gap);
		int n;
		repeat (gap) @(negedge clock_i);
		@(negedge clock_i);
		phase_o = ph;
		data_o = d;
		req_o = 1'b1;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (ack_i !== 1'b1 && n < 60);
		@(negedge clock_i);
		req_o = 1'b0;
		n = 0;
		while (ack_i !== 1'b0 && n < 60) begin
			@(posedge clock_i);
			n++;
		end
		@(negedge clock_i);
		data_o = ~d;
	endtask : offer
endmodule : spce_target_model

// ===== tb/spce_engine_bench.sv
// self-checking bench for the command engine with a behavioural target
`timescale 1ns/10ps
`include "spce_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
	$display("unexpected at %0t: got %0h want %0h", $time, (g), (e)); end end
module spce_engine_bench
	import spce_pkg::*;
;
	logic		clock_i = 1'b0, reset_n_i = 1'b0, done_seen = 1'b0;
	logic		cmd_valid_i = 1'b0, arg_valid_i = 1'b0, arg_end_i = 1'b0;
	spce_cmd_t	cmd_code_i = spce_cmd_cmp;
	logic	[7:0]	arg_char_i = 8'h00;
	logic	[32:0]	dram_free_i = 33'h1_0000_0000;
	logic		gdata_ready_i = 1'b0, stat_ready_i = 1'b0;
	logic		scsi_req_i, scsi_bsy_i, scsi_ack_o, gdata_valid_o, gdata_eoi_o;
	logic		stat_valid_o, identify_disc_o, busy_o, done_o;
	logic	[2:0]	scsi_phase_i;
	logic	[7:0]	scsi_data_i, gdata_o, stat_byte_o, config_byte_o, err_code_o;
	logic	[1:0]	buf_method_o;
	logic	[32:0]	buf_size_o;
	int		miscompares = 0, compares = 0;

	always #25 clock_i = ~clock_i;
	// cleared by the next command so a stale pulse cannot end a later wait
	always @(posedge clock_i) done_seen <= (done_o === 1'b1) | (done_seen & ~cmd_valid_i);

	spce_engine u_spce_engine (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .arg_valid_i(arg_valid_i),
		.arg_char_i(arg_char_i), .arg_end_i(arg_end_i), .dram_free_i(dram_free_i),
		.scsi_req_i(scsi_req_i), .scsi_bsy_i(scsi_bsy_i), .scsi_phase_i(scsi_phase_i),
		.scsi_data_i(scsi_data_i), .scsi_ack_o(scsi_ack_o), .gdata_o(gdata_o),
		.gdata_valid_o(gdata_valid_o), .gdata_eoi_o(gdata_eoi_o),
		.gdata_ready_i(gdata_ready_i), .stat_byte_o(stat_byte_o),
		.stat_valid_o(stat_valid_o), .stat_ready_i(stat_ready_i),
		.config_byte_o(config_byte_o), .buf_method_o(buf_method_o),
		.buf_size_o(buf_size_o), .identify_disc_o(identify_disc_o),
		.err_code_o(err_code_o), .busy_o(busy_o), .done_o(done_o));
	spce_target_model u_target (.clock_i(clock_i), .ack_i(scsi_ack_o), .req_o(scsi_req_i),
		.bsy_o(scsi_bsy_i), .phase_o(scsi_phase_i), .data_o(scsi_data_i));

	task automatic close_out;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	task automatic ran_out;
		miscompares++;
		$display("unexpected at %0t: wait ran out", $time);
		close_out();
	endtask : ran_out
	// the terminator trails the last character by one idle cycle
	task automatic send(input spce_cmd_t c, input string s);
		@(negedge clock_i);
		cmd_valid_i = 1'b1;
		cmd_code_i = c;
		@(negedge clock_i);
		cmd_valid_i = 1'b0;
		for (int i = 0; i < s.len(); i++) begin
			arg_valid_i = 1'b1;
			arg_char_i = s[i];
			@(negedge clock_i);
		end
		arg_valid_i = 1'b0;
		@(negedge clock_i);
		arg_end_i = 1'b1;
		@(negedge clock_i);
		arg_end_i = 1'b0;
	endtask : send
	task automatic pull_stat(input logic [7:0] e);
		int n = 0;
		while (stat_valid_o !== 1'b1) begin
			@(negedge clock_i);
			if (++n > 300) ran_out();
		end
		// one stall cycle so the held status byte is exercised
		@(negedge clock_i);
		`CHK(stat_byte_o, e)
		stat_ready_i = 1'b1;
		@(negedge clock_i);
		stat_ready_i = 1'b0;
	endtask : pull_stat
	// two stall cycles before taking each byte so the held byte is exercised
	task automatic pull_data(input logic [7:0] e, input logic eoi);
		int n = 0;
		while (gdata_valid_o !== 1'b1) begin
			@(negedge clock_i);
			if (++n > 300) ran_out();
		end
		repeat (2) @(negedge clock_i);
		`CHK(gdata_o, e)
		`CHK(gdata_eoi_o, eoi)
		gdata_ready_i = 1'b1;
		@(negedge clock_i);
		gdata_ready_i = 1'b0;
	endtask : pull_data
	task automatic finish_cmd(input logic [7:0] e);
		int n = 0;
		while (done_seen !== 1'b1) begin
			@(negedge clock_i);
			if (++n > 300) ran_out();
		end
		`CHK(err_code_o, e)
		`CHK(busy_o, 1'b0)
	endtask : finish_cmd

	task automatic t_reset;
		`CHK(config_byte_o, `SPCE_CFG_RST)
		`CHK(buf_size_o, `SPCE_BUFSZ_RST)
		`CHK(identify_disc_o, 1'b1)
		$display("test reset done");
	endtask : t_reset
	task automatic t_config;
		logic [7:0] m [4] = '{8'h10, 8'h20, 8'h30, 8'h00};
		logic [1:0] w [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
		send(spce_cmd_config, "52, 2");
		finish_cmd(`SPCE_ERR_NONE);
		`CHK(config_byte_o, 8'h34)
		`CHK(buf_size_o, 33'h2)
		`CHK(identify_disc_o, 1'b0)
		send(spce_cmd_config, "#h20, 4294967296");
		finish_cmd(`SPCE_ERR_NONE);
		`CHK(buf_size_o, 33'h1_0000_0000)
		send(spce_cmd_config, "#h24, #h1Fa");
		finish_cmd(`SPCE_ERR_NONE);
		`CHK(buf_size_o, 33'h1FA)
		dram_free_i = 33'd500;
		send(spce_cmd_config, "#H24, 1000");
		finish_cmd(`SPCE_ERR_NONE);
		`CHK(buf_size_o, 33'd500)
		for (int i = 0; i < 4; i++) begin
			send(spce_cmd_config, $sformatf("%0d", m[i]));
			finish_cmd(`SPCE_ERR_NONE);
			`CHK(buf_method_o, w[i])
			`CHK(buf_size_o, 33'd500)
			`CHK(identify_disc_o, 1'b1)
		end
		$display("test config done");
	endtask : t_config
	task automatic t_query;
		logic [39:0] v = {7'h0, 33'd500};
		send(spce_cmd_config, "?");
		`CHK(busy_o, 1'b1)
		pull_stat(8'h00);
		for (int k = 4; k >= 0; k--) pull_stat(v[k*8 +: 8]);
		pull_stat(`SPCE_CH_CR);
		pull_stat(`SPCE_CH_LF);
		finish_cmd(`SPCE_ERR_NONE);
		$display("test query done");
	endtask : t_query
	task automatic t_bad;
		spce_cmd_t c [7] = '{spce_cmd_config, spce_cmd_config, spce_cmd_config,
			spce_cmd_config, spce_cmd_config, spce_cmd_cmp, spce_cmd_dtin};
		string s [7] = '{"53", "#h10, 1", "#h10, 4294967297", "", "?, 3", "x", "x"};
		for (int i = 0; i < 7; i++) begin
			send(c[i], s[i]);
			pull_stat(`SPCE_ERR_ARG);
			finish_cmd(`SPCE_ERR_ARG);
			`CHK(config_byte_o, 8'h00)
			`CHK(buf_size_o, 33'd500)
		end
		$display("test bad arguments done");
	endtask : t_bad
	task automatic t_cmp;
		u_target.hold_bus();
		fork
			begin
				u_target.offer(`SPCE_PH_STATUS, 8'h02, 0);
				u_target.offer(`SPCE_PH_MSG_IN, 8'h01, 3);
				u_target.offer(`SPCE_PH_MSG_IN, 8'h05, 0);
				u_target.free_bus();
			end
			begin
				send(spce_cmd_cmp, "");
				pull_stat(8'h02);
				pull_stat(8'h01);
				pull_stat(8'h05);
				finish_cmd(`SPCE_ERR_NONE);
				`CHK(stat_valid_o, 1'b0)
			end
		join
		$display("test completion done");
	endtask : t_cmp
	task automatic t_phase;
		spce_cmd_t c [2] = '{spce_cmd_cmp, spce_cmd_dtin};
		logic [2:0] p [2] = '{`SPCE_PH_DATA_IN, `SPCE_PH_STATUS};
		for (int i = 0; i < 2; i++) begin
			u_target.hold_bus();
			fork
				u_target.offer(p[i], 8'h55, 0);
				begin
					send(c[i], "");
					pull_stat(`SPCE_ERR_PHASE);
					finish_cmd(`SPCE_ERR_PHASE);
				end
			join
			u_target.free_bus();
		end
		$display("test phase errors done");
	endtask : t_phase
	task automatic t_dtin;
		u_target.hold_bus();
		fork
			begin
				u_target.offer(`SPCE_PH_DATA_IN, 8'hA1, 0);
				u_target.offer(`SPCE_PH_DATA_IN, 8'hB2, 4);
				u_target.offer(`SPCE_PH_DATA_IN, 8'hC3, 0);
				u_target.free_bus();
			end
			begin
				send(spce_cmd_dtin, "");
				pull_data(8'hA1, 1'b0);
				pull_data(8'hB2, 1'b0);
				pull_data(8'hC3, 1'b1);
				finish_cmd(`SPCE_ERR_NONE);
			end
		join
		$display("test data in done");
	endtask : t_dtin

	initial begin
		repeat (4) @(posedge clock_i);
		@(negedge clock_i);
		reset_n_i = 1'b1;
		t_reset();
		t_config();
		t_query();
		t_bad();
		t_cmp();
		t_phase();
		t_dtin();
		close_out();
	end
endmodule : spce_engine_bench
